// ### pkg/supply_monitor_pkg.sv
// constants and types shared by the supply threshold monitor
package supply_monitor_pkg;

  // time base
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int OSC_PERIOD_NS = 50_000;
  localparam int OSC_TICK_CYCLES = OSC_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int TICK_W = 12;

  // comparator and threshold layout
  localparam int DAC_W = 8;
  localparam int SUPPLY_THRESHOLDS = 4;
  localparam int SUPPLY_VALUES = 5;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] ZERO_VOLT_INDEX = 3'h4;
  localparam int DEB_W = 8;
  localparam int VALID_W = 9;

  // configuration-select thermometer
  localparam int CFG_BITS = 16;
  localparam int CFG_LEVELS = 17;
  localparam int CFG_IDX_W = 4;
  localparam int LEVEL_W = 5;
  localparam logic [CFG_BITS-1:0] CFG_MATCH_RESET = 16'h0000;
  localparam logic [CFG_IDX_W-1:0] CFG_LAST_INDEX = 4'hF;
  localparam logic [LEVEL_W-1:0] UFP_FIRST_LEVEL = 5'h08;
  localparam logic [LEVEL_W-1:0] DFP_FIRST_LEVEL = 5'h0D;
  localparam logic [3:0] CUSTOMER_MAX = 4'hF;
  localparam logic [6:0] CFG_ADDRESS [CFG_LEVELS] = '{
    7'h5F, 7'h5E, 7'h5D, 7'h5C, 7'h6B, 7'h6A, 7'h69, 7'h68,
    7'h5F, 7'h5E, 7'h5D, 7'h5C, 7'h6B,
    7'h6A, 7'h69, 7'h68, 7'h48};

  // power interrupt flag positions
  localparam int PWR_FLAGS = 3;
  localparam int PWR_SUPPLY_CHANGE = 0;
  localparam int PWR_BACKDRIVE_CC1 = 1;
  localparam int CC_PINS = 2;

  // standalone disable field positions
  localparam int STANDALONE_UFP_OFF = 0;
  localparam int STANDALONE_DFP_OFF = 1;
  localparam int PWR_CAP_W = 2;

  typedef enum logic [1:0] {
    MODE_COMPANION,
    MODE_STANDALONE_UFP,
    MODE_STANDALONE_DFP
  } op_mode_t;

  typedef struct packed {
    op_mode_t mode;
    logic [6:0] i2c_address;
    logic [3:0] customer_value;
  } cfg_result_t;

endpackage

// ### hdl/supply_threshold_monitor_cfgsel.sv
// supply threshold sequencer, debouncer, config-select sampler and back-drive guard
`timescale 1ns/100ps

module supply_threshold_monitor_cfgsel
  import supply_monitor_pkg::*;
#(
  parameter int TICK_CYCLES = OSC_TICK_CYCLES,
  parameter bit REDUCED_VARIANT = 1'b0
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic comparator_out,
  input wire logic [SUPPLY_THRESHOLDS-1:0][DAC_W-1:0] supply_threshold,
  input wire logic [DAC_W-1:0] zero_volt_threshold,
  input wire logic [SUPPLY_VALUES-1:0] threshold_write,
  input wire logic [SUPPLY_VALUES-1:0] supply_match_enable,
  input wire logic [SUPPLY_VALUES-1:0] supply_debounce_clear_enable,
  input wire logic [DEB_W-1:0] supply_debounce_time,
  input wire logic [SUPPLY_VALUES-1:0] change_flags_clear,
  input wire logic [CFG_BITS-1:0][DAC_W-1:0] config_select_threshold,
  input wire logic [PWR_CAP_W-1:0] power_capability_pins,
  input wire logic [1:0] standalone_disable,
  input wire logic [CC_PINS-1:0] backdrive_detect,
  input wire logic [CC_PINS-1:0] vconn_request,
  input wire logic vconn_auto_off_enable,
  input wire logic [DEB_W-1:0] backdrive_debounce_time,
  input wire logic [PWR_FLAGS-1:0] power_interrupt_enable,
  input wire logic [PWR_FLAGS-1:0] power_interrupt_clear,
  output logic [DAC_W-1:0] dac_code,
  output logic comparator_select,
  output logic [SUPPLY_VALUES-1:0] supply_match,
  output logic [SUPPLY_VALUES-1:0] supply_change_flags,
  output logic supply_match_valid,
  output logic supply_below_zero_volt,
  output logic [PWR_FLAGS-1:0] power_interrupt_flags,
  output logic irq_b,
  output logic [CFG_BITS-1:0] config_select_match,
  output logic config_done,
  output cfg_result_t cfg_result,
  output logic standalone_dfp_active,
  output logic standalone_ufp_active,
  output logic [PWR_CAP_W-1:0] charge_current_sel,
  output logic [CC_PINS-1:0] vconn_switch_on
);

  typedef enum logic [1:0] {PH_CFG_SETTLE, PH_CFG_SAMPLE, PH_SCAN} phase_t;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  function automatic logic [IDX_W-1:0] next_index(input logic [IDX_W-1:0] cur,
                                                  input logic [SUPPLY_VALUES-1:0] en);
    logic [IDX_W-1:0] pick;
    logic [IDX_W-1:0] cand;
    pick = cur;
    for (int k = SUPPLY_VALUES; k >= 1; k--)
    begin
      cand = IDX_W'((int'(cur) + k) % SUPPLY_VALUES);
      if (en[cand])
        pick = cand;
    end
    return pick;
  endfunction

  function automatic logic [LEVEL_W-1:0] level_of(input logic [CFG_BITS-1:0] code);
    logic [LEVEL_W-1:0] n;
    n = '0;
    for (int k = 0; k < CFG_BITS; k++)
      n = n + LEVEL_W'(code[k]);
    return n;
  endfunction

  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic comp_s1_q;
  logic comp_s2_q;
  logic [CC_PINS-1:0] bd_s1_q;
  logic [CC_PINS-1:0] bd_s2_q;
  logic [PWR_CAP_W-1:0] cap_s1_q;
  logic [PWR_CAP_W-1:0] cap_s2_q;
  phase_t phase_q;
  logic [CFG_IDX_W-1:0] cfg_idx_q;
  logic [CFG_BITS-1:0] cfg_match_q;
  logic config_done_q;
  cfg_result_t cfg_d;
  cfg_result_t cfg_result_q;
  logic [PWR_CAP_W-1:0] charge_q;
  logic [IDX_W-1:0] scan_idx_q;
  logic [DAC_W-1:0] dac_code_q;
  logic comparator_select_q;
  logic [SUPPLY_VALUES-1:0] raw_q;
  logic [SUPPLY_VALUES-1:0] match_vec;
  logic [SUPPLY_VALUES-1:0] upd_w;
  logic [SUPPLY_VALUES-1:0] flags_q;
  logic restart_w;
  logic scan_tick;
  logic [VALID_W-1:0] valid_cnt_q;
  logic valid_q;
  logic below_q;
  logic [PWR_FLAGS-1:0] pwr_flags_q;
  logic irq_b_q;
  logic [CC_PINS-1:0] vconn_on_q;
  logic [CC_PINS-1:0] bd_flag_set;
  logic sa_dfp_q;
  logic sa_ufp_q;

  ////////////////////////////////////////////////////////////////////////////
  // 20 kHz time base and input synchronisers

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      bd_s1_q <= '0;
      bd_s2_q <= '0;
      cap_s1_q <= '0;
      cap_s2_q <= '0;
    end
    else
    begin
      comp_s1_q <= comparator_out;
      comp_s2_q <= comp_s1_q;
      bd_s1_q <= backdrive_detect;
      bd_s2_q <= bd_s1_q;
      cap_s1_q <= power_capability_pins;
      cap_s2_q <= cap_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // config-select sampling, then hand the comparator to supply monitoring

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q <= PH_CFG_SETTLE;
      cfg_idx_q <= '0;
      cfg_match_q <= CFG_MATCH_RESET;
    end
    else if (tick_q)
    begin
      case (phase_q)
        PH_CFG_SETTLE: phase_q <= PH_CFG_SAMPLE;
        PH_CFG_SAMPLE:
        begin
          // each bit needs the one below it, keeping the thermometer form
          cfg_match_q[cfg_idx_q] <= comp_s2_q &
                                    ((cfg_idx_q == '0) || cfg_match_q[cfg_idx_q - 1'b1]);
          if (cfg_idx_q == CFG_LAST_INDEX)
            phase_q <= PH_SCAN;
          else
            cfg_idx_q <= cfg_idx_q + 1'b1;
        end
        default: phase_q <= PH_SCAN;
      endcase
    end
  end

  always_comb
  begin
    logic [LEVEL_W-1:0] level;
    level = level_of(cfg_match_q);
    cfg_d.i2c_address = CFG_ADDRESS[level];
    cfg_d.customer_value = (level > {1'b0, CUSTOMER_MAX}) ? CUSTOMER_MAX : level[3:0];
    if (REDUCED_VARIANT)
      cfg_d.mode = (level >= UFP_FIRST_LEVEL) ? MODE_STANDALONE_UFP : MODE_COMPANION;
    else if (level >= DFP_FIRST_LEVEL)
      cfg_d.mode = MODE_STANDALONE_DFP;
    else if (level >= UFP_FIRST_LEVEL)
      cfg_d.mode = MODE_STANDALONE_UFP;
    else
      cfg_d.mode = MODE_COMPANION;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_done_q <= 1'b0;
      cfg_result_q <= '0;
      charge_q <= '0;
    end
    else if (phase_q == PH_SCAN && !config_done_q)
    begin
      config_done_q <= 1'b1;
      cfg_result_q <= cfg_d;
      charge_q <= cap_s2_q;
    end
  end

  // standalone roles, software may turn either off later
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sa_dfp_q <= 1'b0;
      sa_ufp_q <= 1'b0;
    end
    else
    begin
      sa_dfp_q <= config_done_q && cfg_result_q.mode == MODE_STANDALONE_DFP &&
                  !standalone_disable[STANDALONE_DFP_OFF];
      sa_ufp_q <= config_done_q && cfg_result_q.mode == MODE_STANDALONE_UFP &&
                  !standalone_disable[STANDALONE_UFP_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold sequencer driving the DAC

  assign scan_tick = tick_q && phase_q == PH_SCAN;
  assign restart_w = |threshold_write;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_idx_q <= '0;
      raw_q <= '0;
    end
    else if (scan_tick)
    begin
      if (supply_match_enable[scan_idx_q])
        raw_q[scan_idx_q] <= comp_s2_q;
      scan_idx_q <= next_index(scan_idx_q, supply_match_enable);
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_code_q <= '0;
      comparator_select_q <= 1'b1;
    end
    else
    begin
      comparator_select_q <= (phase_q != PH_SCAN);
      if (phase_q != PH_SCAN)
        dac_code_q <= config_select_threshold[cfg_idx_q];
      else if (scan_idx_q == ZERO_VOLT_INDEX)
        dac_code_q <= zero_volt_threshold;
      else
        dac_code_q <= supply_threshold[scan_idx_q[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-threshold debouncers

  for (genvar i = 0; i < SUPPLY_VALUES; i++)
  begin : g_deb
    logic [DEB_W-1:0] cnt_q;
    logic match_q;
    assign upd_w[i] = scan_tick && supply_match_enable[i] && !restart_w &&
                      raw_q[i] != match_q && cnt_q >= supply_debounce_time;
    assign match_vec[i] = match_q;
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        cnt_q <= '0;
        match_q <= 1'b0;
      end
      else if (!supply_match_enable[i])
      begin
        cnt_q <= '0;
        match_q <= 1'b0;
      end
      else if (restart_w)
        cnt_q <= '0;
      else if (upd_w[i])
      begin
        match_q <= raw_q[i];
        cnt_q <= '0;
      end
      else if (scan_tick)
      begin
        if (raw_q[i] != match_q)
          cnt_q <= cnt_q + 1'b1;
        else if (supply_debounce_clear_enable[i])
          cnt_q <= '0;
      end
    end
  end

  // change flags: a new change wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      flags_q <= '0;
    else
      flags_q <= (flags_q & ~change_flags_clear) | upd_w;
  end

  // results valid after one full round plus the debounce time
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      valid_cnt_q <= '0;
      valid_q <= 1'b0;
    end
    else if (restart_w)
    begin
      valid_cnt_q <= '0;
      valid_q <= 1'b0;
    end
    else if (scan_tick && !valid_q)
    begin
      valid_cnt_q <= valid_cnt_q + 1'b1;
      if (valid_cnt_q >= {1'b0, supply_debounce_time} + VALID_W'(SUPPLY_VALUES))
        valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      below_q <= 1'b0;
    else
      below_q <= valid_q && match_vec == '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // back-drive guard per CC pin

  for (genvar p = 0; p < CC_PINS; p++)
  begin : g_bd
    logic [DEB_W-1:0] bd_cnt_q;
    logic kill_q;
    logic on_q;
    assign bd_flag_set[p] = bd_s2_q[p];
    assign vconn_on_q[p] = on_q;
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        bd_cnt_q <= '0;
        kill_q <= 1'b0;
        on_q <= 1'b0;
      end
      else
      begin
        if (!bd_s2_q[p])
          bd_cnt_q <= '0;
        else if (tick_q && bd_cnt_q < backdrive_debounce_time)
          bd_cnt_q <= bd_cnt_q + 1'b1;
        // off until software drops its request
        if (!vconn_request[p])
          kill_q <= 1'b0;
        else if (vconn_auto_off_enable && bd_s2_q[p] && bd_cnt_q >= backdrive_debounce_time)
          kill_q <= 1'b1;
        on_q <= vconn_request[p] && !kill_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power interrupt flags and request pin

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_flags_q <= '0;
      irq_b_q <= 1'b1;
    end
    else
    begin
      pwr_flags_q <= (pwr_flags_q & ~power_interrupt_clear) |
                     {bd_flag_set, |upd_w};
      irq_b_q <= ~|(pwr_flags_q & power_interrupt_enable);
    end
  end

  assign dac_code = dac_code_q;
  assign comparator_select = comparator_select_q;
  assign supply_match = match_vec;
  assign supply_change_flags = flags_q;
  assign supply_match_valid = valid_q;
  assign supply_below_zero_volt = below_q;
  assign power_interrupt_flags = pwr_flags_q;
  assign irq_b = irq_b_q;
  assign config_select_match = cfg_match_q;
  assign config_done = config_done_q;
  assign cfg_result = cfg_result_q;
  assign standalone_dfp_active = sa_dfp_q;
  assign standalone_ufp_active = sa_ufp_q;
  assign charge_current_sel = charge_q;
  assign vconn_switch_on = vconn_on_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_DAC_ZERO_VOLT: assert property (@(posedge clock) disable iff (!rst_b)
    (phase_q == PH_SCAN && scan_idx_q == ZERO_VOLT_INDEX) |=> dac_code == $past(zero_volt_threshold))
    else $error("dac does not carry zero-volt threshold");
  AST_COMP_SHARED: assert property (@(posedge clock) disable iff (!rst_b)
    !config_done |-> comparator_select)
    else $error("comparator left config-select before config done");
  AST_TICK_SPACING: assert property (@(posedge clock) disable iff (!rst_b)
    tick_q |=> !tick_q [*7])
    else $error("oscillator ticks too close");
  AST_DISABLED_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
    (supply_match & ~$past(supply_match_enable)) == '0)
    else $error("disabled threshold kept a match bit");
  AST_IRQ_ON_CHANGE: assert property (@(posedge clock) disable iff (!rst_b)
    (|upd_w && power_interrupt_enable[PWR_SUPPLY_CHANGE] && power_interrupt_clear == '0)
    ##1 (power_interrupt_enable[PWR_SUPPLY_CHANGE] && power_interrupt_clear == '0) |=> !irq_b)
    else $error("interrupt pin not asserted after supply change");
  AST_RESTART_INVALID: assert property (@(posedge clock) disable iff (!rst_b)
    restart_w |=> !supply_match_valid [*2])
    else $error("valid survived a threshold write");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!rst_b)
    (upd_w[0] && change_flags_clear[0]) |=> supply_change_flags[0])
    else $error("change flag lost to a clear");
  AST_BELOW_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
    (supply_match_valid && supply_match == '0) |=> supply_below_zero_volt)
    else $error("below-zero indication missing");
  AST_THERMOMETER: assert property (@(posedge clock) disable iff (!rst_b)
    config_done |-> ((config_select_match + 17'h0_0001) & {1'b0, config_select_match}) == '0)
    else $error("config-select match is not a thermometer code");
  AST_BACKDRIVE_FLAG: assert property (@(posedge clock) disable iff (!rst_b)
    (bd_s2_q[0] && !power_interrupt_clear[PWR_BACKDRIVE_CC1]) |=>
    power_interrupt_flags[PWR_BACKDRIVE_CC1])
    else $error("back-drive flag not set");
  AST_VCONN_OFF: assert property (@(posedge clock) disable iff (!rst_b)
    (g_bd[0].kill_q && vconn_request[0]) |=> !vconn_switch_on[0])
    else $error("vconn stayed on after back-drive");

endmodule

// ### tb/supply_partner.sv
// comparator model standing in for the divided supply and the config resistor
`timescale 1ns/100ps

module supply_partner
  import supply_monitor_pkg::*;
(
  input wire logic [DAC_W-1:0] dac_code,
  input wire logic comparator_select,
  input wire logic [DAC_W-1:0] supply_level,
  input wire logic [DAC_W-1:0] config_level,
  output logic comparator_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // one comparator, its input picked by the select line
  assign comparator_out = comparator_select ? (config_level > dac_code)
                                            : (supply_level > dac_code);

endmodule

// ### tb/supply_threshold_monitor_cfgsel_tb.sv
// self-checking bench for the supply threshold monitor and config-select sampler
`timescale 1ns/100ps

module supply_threshold_monitor_cfgsel_tb
  import supply_monitor_pkg::*;
;
  localparam int TICKS = 8;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic comparator_out;
  logic [SUPPLY_THRESHOLDS-1:0][DAC_W-1:0] supply_threshold;
  logic [DAC_W-1:0] zero_volt_threshold = 8'h0A;
  logic [SUPPLY_VALUES-1:0] threshold_write = '0;
  logic [SUPPLY_VALUES-1:0] supply_match_enable = 5'h1F;
  logic [SUPPLY_VALUES-1:0] supply_debounce_clear_enable = 5'h1F;
  logic [DEB_W-1:0] supply_debounce_time = 8'h02;
  logic [SUPPLY_VALUES-1:0] change_flags_clear = '0;
  logic [CFG_BITS-1:0][DAC_W-1:0] config_select_threshold;
  logic [PWR_CAP_W-1:0] power_capability_pins = 2'h2;
  logic [1:0] standalone_disable = 2'h0;
  logic [CC_PINS-1:0] backdrive_detect = '0;
  logic [CC_PINS-1:0] vconn_request = 2'h3;
  logic vconn_auto_off_enable = 1'b1;
  logic [DEB_W-1:0] backdrive_debounce_time = 8'h02;
  logic [PWR_FLAGS-1:0] power_interrupt_enable = 3'h3;
  logic [PWR_FLAGS-1:0] power_interrupt_clear = '0;
  logic [DAC_W-1:0] dac_code;
  logic comparator_select;
  logic [SUPPLY_VALUES-1:0] supply_match;
  logic [SUPPLY_VALUES-1:0] supply_change_flags;
  logic supply_match_valid;
  logic supply_below_zero_volt;
  logic [PWR_FLAGS-1:0] power_interrupt_flags;
  logic irq_b;
  logic [CFG_BITS-1:0] config_select_match;
  logic config_done;
  cfg_result_t cfg_result;
  cfg_result_t cfg_reduced;
  logic standalone_dfp_active;
  logic standalone_ufp_active;
  logic [PWR_CAP_W-1:0] charge_current_sel;
  logic [CC_PINS-1:0] vconn_switch_on;
  logic [DAC_W-1:0] supply_level = 8'h00;
  logic [DAC_W-1:0] config_level = 8'h00;
  int errors = 0;
  int compares = 0;
  // expected address per thermometer level
  logic [6:0] addr_table [17] = '{7'h5F, 7'h5E, 7'h5D, 7'h5C, 7'h6B, 7'h6A, 7'h69, 7'h68,
    7'h5F, 7'h5E, 7'h5D, 7'h5C, 7'h6B, 7'h6A, 7'h69, 7'h68, 7'h48};

  always #20 clock = ~clock;

  initial
  begin
    supply_threshold = {8'h96, 8'h78, 8'h32, 8'h28};
    for (int i = 0; i < CFG_BITS; i++)
      config_select_threshold[i] = 8'(8 * (i + 1));
  end

  supply_threshold_monitor_cfgsel #(.TICK_CYCLES(TICKS), .REDUCED_VARIANT(1'b0)) u_dut (
    .clock(clock),
    .rst_b(rst_b),
    .comparator_out(comparator_out),
    .supply_threshold(supply_threshold),
    .zero_volt_threshold(zero_volt_threshold),
    .threshold_write(threshold_write),
    .supply_match_enable(supply_match_enable),
    .supply_debounce_clear_enable(supply_debounce_clear_enable),
    .supply_debounce_time(supply_debounce_time),
    .change_flags_clear(change_flags_clear),
    .config_select_threshold(config_select_threshold),
    .power_capability_pins(power_capability_pins),
    .standalone_disable(standalone_disable),
    .backdrive_detect(backdrive_detect),
    .vconn_request(vconn_request),
    .vconn_auto_off_enable(vconn_auto_off_enable),
    .backdrive_debounce_time(backdrive_debounce_time),
    .power_interrupt_enable(power_interrupt_enable),
    .power_interrupt_clear(power_interrupt_clear),
    .dac_code(dac_code),
    .comparator_select(comparator_select),
    .supply_match(supply_match),
    .supply_change_flags(supply_change_flags),
    .supply_match_valid(supply_match_valid),
    .supply_below_zero_volt(supply_below_zero_volt),
    .power_interrupt_flags(power_interrupt_flags),
    .irq_b(irq_b),
    .config_select_match(config_select_match),
    .config_done(config_done),
    .cfg_result(cfg_result),
    .standalone_dfp_active(standalone_dfp_active),
    .standalone_ufp_active(standalone_ufp_active),
    .charge_current_sel(charge_current_sel),
    .vconn_switch_on(vconn_switch_on)
  );

  // reduced variant, same inputs and so the same dac sequence as u_dut
  supply_threshold_monitor_cfgsel #(.TICK_CYCLES(TICKS), .REDUCED_VARIANT(1'b1)) u_dut_reduced (
    .clock(clock),
    .rst_b(rst_b),
    .comparator_out(comparator_out),
    .supply_threshold(supply_threshold),
    .zero_volt_threshold(zero_volt_threshold),
    .threshold_write(threshold_write),
    .supply_match_enable(supply_match_enable),
    .supply_debounce_clear_enable(supply_debounce_clear_enable),
    .supply_debounce_time(supply_debounce_time),
    .change_flags_clear(change_flags_clear),
    .config_select_threshold(config_select_threshold),
    .power_capability_pins(power_capability_pins),
    .standalone_disable(standalone_disable),
    .backdrive_detect(backdrive_detect),
    .vconn_request(vconn_request),
    .vconn_auto_off_enable(vconn_auto_off_enable),
    .backdrive_debounce_time(backdrive_debounce_time),
    .power_interrupt_enable(power_interrupt_enable),
    .power_interrupt_clear(power_interrupt_clear),
    .dac_code(),
    .comparator_select(),
    .supply_match(),
    .supply_change_flags(),
    .supply_match_valid(),
    .supply_below_zero_volt(),
    .power_interrupt_flags(),
    .irq_b(),
    .config_select_match(),
    .config_done(),
    .cfg_result(cfg_reduced),
    .standalone_dfp_active(),
    .standalone_ufp_active(),
    .charge_current_sel(),
    .vconn_switch_on()
  );

  supply_partner u_partner (
    .dac_code(dac_code),
    .comparator_select(comparator_select),
    .supply_level(supply_level),
    .config_level(config_level),
    .comparator_out(comparator_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic do_reset();
    int n;
    n = 0;
    rst_b = 1'b0;
    step(10);
    rst_b = 1'b1;
    while (config_done !== 1'b1 && n < 2000)
    begin
      step(1);
      n++;
    end
    step(2);
  endtask

  task automatic wait_match(input logic [4:0] exp);
    int n;
    n = 0;
    while (supply_match !== exp && n < 1000)
    begin
      step(1);
      n++;
    end
    chk("supply_match", 16'(exp), 16'(supply_match));
  endtask

  task automatic finish_test();
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial
  begin
    int n;
    op_mode_t m;
    // every config-select level after a fresh reset
    for (int lv = 0; lv <= 16; lv++)
    begin
      config_level = (lv == 0) ? 8'h00 : 8'(8 * lv + 4);
      do_reset();
      m = (lv >= 13) ? MODE_STANDALONE_DFP : (lv >= 8) ? MODE_STANDALONE_UFP : MODE_COMPANION;
      chk("cfg_match", 16'((32'h0000_0001 << lv) - 32'h0000_0001), config_select_match);
      chk("cfg_mode", 16'(m), 16'(cfg_result.mode));
      chk("cfg_addr", 16'(addr_table[lv]), 16'(cfg_result.i2c_address));
      chk("customer", 16'((lv > 15) ? 15 : lv), 16'(cfg_result.customer_value));
      chk("mode_reduced", 16'((lv >= 8) ? MODE_STANDALONE_UFP : MODE_COMPANION), 16'(cfg_reduced.mode));
      chk("dfp_active", 16'(lv >= 13), 16'(standalone_dfp_active));
      chk("ufp_active", 16'(lv >= 8 && lv < 13), 16'(standalone_ufp_active));
      chk("cmp_select", 16'h0000, 16'(comparator_select));
      if (lv >= 13)
        chk("charge_sel", 16'(power_capability_pins), 16'(charge_current_sel));
    end
    // software turns standalone DFP off
    standalone_disable = 2'h2;
    step(3);
    chk("dfp_active", 16'h0000, 16'(standalone_dfp_active));
    // supply between thresholds 1 and 2
    supply_level = 8'h50;
    n = 0;
    while (supply_match_valid !== 1'b1 && n < 1000)
    begin
      step(1);
      n++;
    end
    chk("valid", 16'h0001, 16'(supply_match_valid));
    wait_match(5'h13);
    chk("below_zero", 16'h0000, 16'(supply_below_zero_volt));
    change_flags_clear = 5'h1F;
    power_interrupt_clear = 3'h1;
    step(1);
    change_flags_clear = '0;
    power_interrupt_clear = '0;
    step(2);
    chk("irq_b", 16'h0001, 16'(irq_b));
    // supply collapses below every threshold
    supply_level = 8'h00;
    wait_match(5'h00);
    step(3);
    chk("chg_flags", 16'h0013, 16'(supply_change_flags));
    chk("pwr_flag", 16'h0001, 16'(power_interrupt_flags[PWR_SUPPLY_CHANGE]));
    chk("irq_b", 16'h0000, 16'(irq_b));
    chk("below_zero", 16'h0001, 16'(supply_below_zero_volt));
    change_flags_clear = 5'h1F;
    power_interrupt_clear = 3'h1;
    step(1);
    change_flags_clear = '0;
    power_interrupt_clear = '0;
    step(2);
    chk("chg_flags", 16'h0000, 16'(supply_change_flags));
    chk("irq_b", 16'h0001, 16'(irq_b));
    // threshold 3 left out of the scan
    supply_match_enable = 5'h17;
    supply_level = 8'hC8;
    wait_match(5'h17);
    step(200);
    chk("match_off", 16'h0000, 16'(supply_match[3]));
    // a threshold write restarts the debouncer
    threshold_write = 5'h04;
    step(1);
    threshold_write = '0;
    step(1);
    chk("valid_restart", 16'h0000, 16'(supply_match_valid));
    // back-drive on the first CC pin, only its flag may pull the pin
    power_interrupt_enable = 3'h2;
    step(2);
    chk("irq_idle", 16'h0001, 16'(irq_b));
    chk("vconn_on", 16'h0003, 16'(vconn_switch_on));
    backdrive_detect = 2'h1;
    n = 0;
    while (vconn_switch_on[0] !== 1'b0 && n < 400)
    begin
      step(1);
      n++;
    end
    chk("bd_flag", 16'h0001, 16'(power_interrupt_flags[PWR_BACKDRIVE_CC1]));
    chk("vconn_off", 16'h0002, 16'(vconn_switch_on));
    chk("irq_bd", 16'h0000, 16'(irq_b));
    finish_test();
  end

endmodule
